// ### hdl/dswc_defs.svh
`ifndef DSWC_DEFS_SVH
`define DSWC_DEFS_SVH
// ==========================================================
// Register offsets
`define DSWC_CTRL_OFS     8'h00
`define DSWC_WAKE_EN_OFS  8'h04
`define DSWC_WAKE_DLY_OFS 8'h08
`define DSWC_CAUSE_OFS    8'h0c
`define DSWC_MASK_OFS     8'h10
`define DSWC_STATE_OFS    8'h14
// ==========================================================
// Field positions
`define DSWC_CTRL_SLEEP_BIT   0
`define DSWC_CTRL_WDT_IRQ_BIT 1
`define DSWC_CTRL_IRQ_EN_BIT  2
`define DSWC_CTRL_WDT_ACK_BIT 3
`define DSWC_CAUSE_EXIT_BIT   0
`define DSWC_CAUSE_WDT_BIT    1
`define DSWC_CAUSE_EXT_BIT    2
`define DSWC_CAUSE_DBG_BIT    3
// ==========================================================
// Reset values
`define DSWC_WAKE_DLY_RST 16'h0010
`define DSWC_WAKE_EN_RST  8'h00
`define DSWC_MASK_RST     4'h0
// ==========================================================
// Timing
`define DSWC_CLK_PERIOD_NS 5
`define DSWC_MIN_PULSE_NS  50
`define DSWC_MIN_PULSE_CYC ((`DSWC_MIN_PULSE_NS + `DSWC_CLK_PERIOD_NS - 1) / `DSWC_CLK_PERIOD_NS)
`endif

// ### hdl/dswc_pkg.sv
package dswc_pkg;
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_QUAL, ST_WAKE, ST_RESET} dswc_state_e;
  typedef struct packed {
    logic wdt_irq_mode;
    logic irq_en;
  } dswc_cfg_s;
  typedef struct packed {
    logic dbg;
    logic ext;
    logic wdt;
    logic sleep_exit;
  } dswc_cause_s;
endpackage

// ### hdl/dswc_top.sv
`include "dswc_defs.svh"

// How it works
// - Completed wake sets the sleep exit flag
// - Watchdog reset mode in sleep wakes instead
// - Watchdog interrupt mode wakes, then raises interrupt
// - Watchdog time-out sets watchdog and exit flags
// - Watchdog interrupt only after wake, if enabled
// - Each port pin has its own wake enable
// - Rising or falling edge on enabled pin wakes
// - External reset pin in sleep: full reset
// - Debug pin low in sleep: full reset
// - Too short pulse: no wake, exit flag set
// - Port inputs frozen; capture level at delay end
module dswc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  port_pin,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        debug_pin,
  input  wire logic        wdt_timeout,
  output logic      [7:0]  port_input_data,
  output logic             cpu_clk_en,
  output logic             sys_reset_req,
  output logic             wdt_irq,
  output logic             irq,
  output logic             in_deep_sleep
);

  localparam int          NPIN    = 8;
  localparam int          NSYNC   = NPIN + 2;
  localparam logic [7:0]  MIN_CYC = 8'(`DSWC_MIN_PULSE_CYC);

  // ==========================================================
  // Pin synchronisers
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] lvl_r;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[gi]  <= 1'b1;
          s2_r[gi]  <= 1'b1;
          s3_r[gi]  <= 1'b1;
          lvl_r[gi] <= 1'b1;
        end else begin
          s1_r[gi] <= (gi < NPIN) ? port_pin[gi % NPIN] : ((gi == NPIN) ? ext_reset_pin_n : debug_pin);
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            lvl_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  logic [NPIN-1:0] pin_lvl;
  logic            ext_rst_act;
  logic            dbg_low;
  assign pin_lvl     = lvl_r[NPIN-1:0];
  assign ext_rst_act = ~lvl_r[NPIN];
  assign dbg_low     = ~lvl_r[NPIN+1];

  // ==========================================================
  // Registers and APB decode
  dswc_pkg::dswc_cfg_s   cfg_r;
  dswc_pkg::dswc_cause_s cause_r;
  dswc_pkg::dswc_state_e state_r;
  logic [NPIN-1:0] wake_en_r;
  logic [15:0]     wake_dly_r;
  logic [3:0]      mask_r;
  logic            sleep_cmd;
  logic            wdt_ack;
  logic            wr_en;
  logic            rd_setup;
  logic            cause_rd;
  logic            addr_ok;

  assign wr_en     = psel & penable & pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign cause_rd  = psel & penable & ~pwrite & (paddr == `DSWC_CAUSE_OFS);
  assign addr_ok   = (paddr == `DSWC_CTRL_OFS) | (paddr == `DSWC_WAKE_EN_OFS) | (paddr == `DSWC_WAKE_DLY_OFS) |
                     (paddr == `DSWC_CAUSE_OFS) | (paddr == `DSWC_MASK_OFS) | (paddr == `DSWC_STATE_OFS);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_ok;
  assign sleep_cmd = wr_en & (paddr == `DSWC_CTRL_OFS) & pwdata[`DSWC_CTRL_SLEEP_BIT];
  assign wdt_ack   = wr_en & (paddr == `DSWC_CTRL_OFS) & pwdata[`DSWC_CTRL_WDT_ACK_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r      <= '0;
      wake_en_r  <= `DSWC_WAKE_EN_RST;
      wake_dly_r <= `DSWC_WAKE_DLY_RST;
      mask_r     <= `DSWC_MASK_RST;
    end else if (wr_en) begin
      case (paddr)
        `DSWC_CTRL_OFS: begin
          cfg_r.wdt_irq_mode <= pwdata[`DSWC_CTRL_WDT_IRQ_BIT];
          cfg_r.irq_en       <= pwdata[`DSWC_CTRL_IRQ_EN_BIT];
        end
        `DSWC_WAKE_EN_OFS:  wake_en_r  <= pwdata[NPIN-1:0];
        `DSWC_WAKE_DLY_OFS: wake_dly_r <= pwdata[15:0];
        `DSWC_MASK_OFS:     mask_r     <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      case (paddr)
        `DSWC_CTRL_OFS:     prdata <= {28'h0, wdt_irq, cfg_r.irq_en, cfg_r.wdt_irq_mode, 1'b0};
        `DSWC_WAKE_EN_OFS:  prdata <= {24'h0, wake_en_r};
        `DSWC_WAKE_DLY_OFS: prdata <= {16'h0, wake_dly_r};
        `DSWC_CAUSE_OFS:    prdata <= {28'h0, cause_r};
        `DSWC_MASK_OFS:     prdata <= {28'h0, mask_r};
        `DSWC_STATE_OFS:    prdata <= {21'h0, state_r, pin_lvl};
        default:            prdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // Sleep and wake sequencer
  logic [NPIN-1:0] ref_r;
  logic [NPIN-1:0] qual_r;
  logic [7:0]      qcnt_r;
  logic [15:0]     dcnt_r;
  logic [NPIN-1:0] pin_chg;
  logic            asleep;
  logic            rst_evt;
  logic            wdt_evt;
  logic            qual_lost;
  logic            qual_done;
  logic            wake_done;
  logic            wdt_irq_pend_r;

  assign pin_chg   = (pin_lvl ^ ref_r) & wake_en_r;
  assign asleep    = (state_r == dswc_pkg::ST_SLEEP) | (state_r == dswc_pkg::ST_QUAL);
  assign rst_evt   = asleep & (ext_rst_act | dbg_low);
  assign wdt_evt   = asleep & wdt_timeout & ~rst_evt;
  assign qual_lost = ((pin_lvl ^ ref_r) & qual_r) == '0;
  assign qual_done = qcnt_r >= MIN_CYC - 8'h01;
  assign wake_done = (state_r == dswc_pkg::ST_WAKE) & (dcnt_r >= wake_dly_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= dswc_pkg::ST_RUN;
    end else begin
      case (state_r)
        dswc_pkg::ST_RUN: begin
          if (sleep_cmd) begin
            state_r <= dswc_pkg::ST_SLEEP;
          end
        end
        dswc_pkg::ST_SLEEP: begin
          if (rst_evt) begin
            state_r <= dswc_pkg::ST_RESET;
          end else if (wdt_evt) begin
            state_r <= dswc_pkg::ST_WAKE;
          end else if (pin_chg != '0) begin
            state_r <= dswc_pkg::ST_QUAL;
          end
        end
        dswc_pkg::ST_QUAL: begin
          if (rst_evt) begin
            state_r <= dswc_pkg::ST_RESET;
          end else if (wdt_evt) begin
            state_r <= dswc_pkg::ST_WAKE;
          end else if (qual_lost) begin
            state_r <= dswc_pkg::ST_SLEEP;
          end else if (qual_done) begin
            state_r <= dswc_pkg::ST_WAKE;
          end
        end
        dswc_pkg::ST_WAKE: begin
          if (wake_done) begin
            state_r <= dswc_pkg::ST_RUN;
          end
        end
        dswc_pkg::ST_RESET: state_r <= dswc_pkg::ST_RUN;
        default:            state_r <= dswc_pkg::ST_RUN;
      endcase
    end
  end

  // Reference levels and qualifying pin set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_r  <= '1;
      qual_r <= '0;
      qcnt_r <= '0;
    end else begin
      if (state_r == dswc_pkg::ST_RUN) begin
        ref_r <= pin_lvl;
      end
      if (state_r == dswc_pkg::ST_SLEEP) begin
        qual_r <= pin_chg;
        qcnt_r <= '0;
      end else if (state_r == dswc_pkg::ST_QUAL && qcnt_r != 8'hff) begin
        qcnt_r <= qcnt_r + 8'h01;
      end
    end
  end

  // Wake delay counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_r <= '0;
    end else if (state_r == dswc_pkg::ST_WAKE) begin
      if (dcnt_r != 16'hffff) begin
        dcnt_r <= dcnt_r + 16'h0001;
      end
    end else begin
      dcnt_r <= '0;
    end
  end

  // Port input data frozen in sleep, captured at end of wake delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_input_data <= '0;
    end else if (state_r == dswc_pkg::ST_RUN || wake_done) begin
      port_input_data <= pin_lvl;
    end
  end

  // ==========================================================
  // Cause flags, interrupt and outputs
  dswc_pkg::dswc_cause_s cause_set;
  always_comb begin
    cause_set            = '0;
    cause_set.sleep_exit = wake_done | wdt_evt |
                           ((state_r == dswc_pkg::ST_QUAL) & ~rst_evt & ~wdt_evt & qual_lost);
    cause_set.wdt        = wdt_evt;
    cause_set.ext        = asleep & ext_rst_act;
    cause_set.dbg        = asleep & dbg_low;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= '0;
    end else begin
      cause_r <= (cause_rd ? '0 : cause_r) | cause_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_irq_pend_r <= 1'b0;
    end else if (wdt_evt && cfg_r.wdt_irq_mode) begin
      wdt_irq_pend_r <= 1'b1;
    end else if (wdt_ack) begin
      wdt_irq_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_req <= 1'b0;
      irq           <= 1'b0;
    end else begin
      sys_reset_req <= rst_evt;
      irq           <= |(cause_r & mask_r);
    end
  end

  assign wdt_irq       = wdt_irq_pend_r & cfg_r.irq_en & (state_r == dswc_pkg::ST_RUN);
  assign cpu_clk_en    = (state_r == dswc_pkg::ST_RUN);
  assign in_deep_sleep = ~cpu_clk_en;

  // ==========================================================
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wake_exit_a: assert property (wake_done |=> cause_r.sleep_exit && state_r == dswc_pkg::ST_RUN)
    else $error("Wake end did not set exit flag");
  wdt_rst_a: assert property (wdt_evt && !cfg_r.wdt_irq_mode |=> state_r == dswc_pkg::ST_WAKE && !sys_reset_req)
    else $error("Watchdog reset mode did not wake");
  wdt_irq_a: assert property (wdt_evt && cfg_r.wdt_irq_mode |=> !wdt_irq ##1 wdt_irq_pend_r)
    else $error("Watchdog interrupt not held pending");
  wdt_flags_a: assert property (wdt_evt |=> cause_r.wdt && cause_r.sleep_exit)
    else $error("Watchdog flags not set");
  irq_gate_a: assert property (wdt_irq |-> cfg_r.irq_en && state_r == dswc_pkg::ST_RUN)
    else $error("Watchdog interrupt raised during wake");
  pin_wake_a: assert property (state_r == dswc_pkg::ST_SLEEP && pin_chg != '0 && !rst_evt && !wdt_evt
                               |=> state_r == dswc_pkg::ST_QUAL)
    else $error("Pin change ignored");
  ext_rst_a: assert property (asleep && ext_rst_act |=> sys_reset_req ##1 !sys_reset_req)
    else $error("External reset not forwarded");
  dbg_rst_a: assert property (asleep && dbg_low |=> sys_reset_req && state_r == dswc_pkg::ST_RESET)
    else $error("Debug low not forwarded");
  short_pulse_a: assert property (state_r == dswc_pkg::ST_QUAL && qual_lost && !rst_evt && !wdt_evt
                                  |=> state_r == dswc_pkg::ST_SLEEP && cause_r.sleep_exit)
    else $error("Short pulse handled wrongly");
  port_frozen_a: assert property (state_r != dswc_pkg::ST_RUN && !wake_done |=> $stable(port_input_data))
    else $error("Port data changed in sleep");
  clk_gate_a: assert property (state_r == dswc_pkg::ST_WAKE && !wake_done |=> !cpu_clk_en)
    else $error("Clock resumed before delay end");

endmodule

// ### verification/dswc_wake_src.sv
// ==========================================================
// Wake sources: port pins, watchdog, reset and debug pins
module dswc_wake_src (
  output logic [7:0] port_pin,
  output logic       ext_reset_pin_n,
  output logic       debug_pin,
  output logic       wdt_timeout,
  input  wire logic  pclk
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins rest high on their pull-ups
  initial begin
    port_pin        = 8'hff;
    ext_reset_pin_n = 1'b1;
    debug_pin       = 1'b1;
    wdt_timeout     = 1'b0;
  end
  task automatic set_pins(input logic [7:0] v, input int hold);
    @(posedge pclk);
    port_pin <= v;
    repeat (hold) @(posedge pclk);
  endtask
  task automatic wdt_pulse();
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
  endtask
  task automatic reset_pins(input logic ext, input int hold);
    @(posedge pclk);
    if (ext) ext_reset_pin_n <= 1'b0;
    else debug_pin <= 1'b0;
    repeat (hold) @(posedge pclk);
    ext_reset_pin_n <= 1'b1;
    debug_pin       <= 1'b1;
  endtask
endmodule

// ### verification/deep_sleep_wake_control_tb.sv
module deep_sleep_wake_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] wd;
    logic [31:0] rd;
    logic        err;
  } dswc_row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, port_pin, port_input_data;
  logic [31:0] pwdata, prdata, rd;
  logic        ext_reset_pin_n, debug_pin, wdt_timeout, cpu_clk_en;
  logic        sys_reset_req, wdt_irq, irq, in_deep_sleep, er;
  int          fails, n_checks, rst_seen, rst_base;
  dswc_row_s   rows[13] = '{
    '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h10, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h14, 32'h0, 32'hff, 1'b0}, '{1'b1, 8'h04, 32'h1, 32'h0, 1'b0},
    '{1'b1, 8'h08, 32'h2, 32'h0, 1'b0}, '{1'b1, 8'h10, 32'hfffffff1, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h1, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h2, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h1, 1'b0}, '{1'b1, 8'h18, 32'h5, 32'h0, 1'b1},
    '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1}};

  dswc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_pin(port_pin), .ext_reset_pin_n(ext_reset_pin_n), .debug_pin(debug_pin),
    .wdt_timeout(wdt_timeout), .port_input_data(port_input_data), .cpu_clk_en(cpu_clk_en),
    .sys_reset_req(sys_reset_req), .wdt_irq(wdt_irq), .irq(irq), .in_deep_sleep(in_deep_sleep));
  dswc_wake_src src (.port_pin(port_pin), .ext_reset_pin_n(ext_reset_pin_n), .debug_pin(debug_pin),
    .wdt_timeout(wdt_timeout), .pclk(pclk));

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog process ends a wait for a slave that never raises pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sleep(input logic [31:0] ctrl);
    apb(1'b1, 8'h00, ctrl);
    repeat (2) @(posedge pclk);
    check(in_deep_sleep, 1'b1);
  endtask
  task automatic wait_run();
    for (int i = 0; i < 80 && cpu_clk_en !== 1'b1; i++) @(posedge pclk);
    check(cpu_clk_en, 1'b1);
  endtask
  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge pclk) if (sys_reset_req === 1'b1) rst_seen++;
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].wd);
      if (!rows[i].wr) check(rd, rows[i].rd);
      check({31'h0, pready}, 32'h1);
      check({31'h0, er}, {31'h0, rows[i].err});
    end
    for (int lv = 0; lv < 2; lv++) begin
      sleep(32'h1);
      src.set_pins({7'h7f, lv[0]}, 0);
      wait_run();
      check(port_input_data, {7'h7f, lv[0]});
      repeat (2) @(posedge pclk);
      check(irq, 1'b1);
      apb(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h1);
      repeat (2) @(posedge pclk);
      check(irq, 1'b0);
    end
    sleep(32'h1);
    src.set_pins(8'hfd, 30);
    check(cpu_clk_en, 1'b0);
    check(port_input_data, 8'hff);
    src.set_pins(8'hfc, 3);
    src.set_pins(8'hfd, 30);
    check(cpu_clk_en, 1'b0);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h1);
    src.set_pins(8'hfc, 0);
    wait_run();
    check(port_input_data, 8'hfc);
    apb(1'b0, 8'h0c, 32'h0);
    rst_base = rst_seen;
    sleep(32'h1);
    src.wdt_pulse();
    wait_run();
    check(rst_seen - rst_base, 0);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h3);
    for (int en = 0; en < 2; en++) begin
      sleep({29'h0, en[0], 2'b11});
      src.wdt_pulse();
      @(posedge pclk);
      check(wdt_irq, 1'b0);
      wait_run();
      @(posedge pclk);
      check(wdt_irq, en[0]);
      apb(1'b1, 8'h00, {28'h0, 1'b1, en[0], 2'b10});
      @(posedge pclk);
      check(wdt_irq, 1'b0);
      apb(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h3);
    end
    for (int k = 0; k < 2; k++) begin
      rst_base = rst_seen;
      sleep(32'h1);
      src.reset_pins(k == 0, 6);
      repeat (6) @(posedge pclk);
      check(rst_seen > rst_base, 1'b1);
      check(cpu_clk_en, 1'b1);
      check(irq, 1'b0);
      apb(1'b0, 8'h0c, 32'h0);
      check(rd, (k == 0) ? 32'h4 : 32'h8);
    end
    // Reset taken in the middle of a sleep
    sleep(32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(cpu_clk_en, 1'b1);
    check(in_deep_sleep, 1'b0);
    check(sys_reset_req, 1'b0);
    check(prdata, 32'h0);
    check({wdt_irq, irq}, 2'b00);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h10);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    check(cpu_clk_en, 1'b1);
    report_and_stop();
  end
endmodule
